// File: src/ipb_pkg.sv
// Purpose: Shared constants and types for the priority level register bank
// Assumes: 32-bit AXI4-Lite data, one 16-bit register per aligned word
// Notes: Source numbering below is the order of the level outputs
`default_nettype none
package ipb_pkg;
    // Register map, byte addresses
    localparam int unsigned REG_COUNT = 6;
    localparam logic [7:0] OFS_TIMER6_DMA4_OC8 = 8'h00;
    localparam logic [7:0] OFS_TIMER8_I2C2_TIMER7 = 8'h04;
    localparam logic [7:0] OFS_CAN2RX_EXTINT_TIMER9 = 8'h08;
    localparam logic [7:0] OFS_ENCODER_PWM_CAN2 = 8'h0c;
    localparam logic [7:0] OFS_FAULTA_DMA5 = 8'h10;
    localparam logic [7:0] OFS_UART_ERRORS_FAULTB = 8'h14;
    localparam int unsigned WORD_LSB = 2;
    localparam int unsigned REG_WIDTH = 16;
    localparam int unsigned LEVEL_WIDTH = 3;
    // Bits that hold a level field; all others are unimplemented
    localparam logic [15:0] REG_MASK [0:5] = '{
        16'h7707, 16'h7777, 16'h7777, 16'h0777, 16'h7070, 16'h0777};
    // Every field starts at level four
    localparam logic [2:0] LEVEL_RESET = 3'h4;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [15:0] REG_RESET [0:5] = '{
        16'h4404, 16'h4444, 16'h4444, 16'h0444, 16'h4040, 16'h0444};
    // Sources: register index and field lsb
    localparam int unsigned SRC_COUNT = 19;
    // 0 timer6, 1 dma_ch4_done, 2 compare8, 3 timer8, 4 i2c2_master,
    // 5 i2c2_slave, 6 timer7, 7 can2_receive, 8 ext_irq4, 9 ext_irq3,
    // 10 timer9, 11 encoder, 12 motor_pwm, 13 can2_event, 14 fault_a,
    // 15 dma_ch5_done, 16 uart2_error, 17 uart1_error, 18 fault_b
    localparam int unsigned SRC_REG [0:18] = '{
        0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 5, 5, 5};
    localparam int unsigned SRC_LSB [0:18] = '{
        12, 8, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 4, 8, 4, 0};
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } ipb_wr_state_type;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } ipb_rd_state_type;
endpackage
`default_nettype wire

// File: src/ipb_level_if.sv
// Purpose: Carries levels and requests between register bank and gate
// Assumes: Single clock domain, no timing of its own
// Notes: Levels are straight register bits
`default_nettype none
interface ipb_level_if #(
    parameter int unsigned N = 19
);
    logic [2:0] level [0:N-1];
    logic [N-1:0] req;
    logic [N-1:0] fwd;
    modport bank (output level, output req, input fwd);
    modport gate (input level, input req, output fwd);
endinterface
`default_nettype wire

// File: src/ipb_src_gate.sv
// Purpose: Forwards a source request only when its level is nonzero
// Assumes: Requests come from logic on core_clk, no synchroniser needed
// Notes: Purely combinational so no latency is added past the registers
`default_nettype none
module ipb_src_gate #(
    parameter int unsigned N = 19
) (
    input wire logic core_clk,
    input wire logic srst,
    ipb_level_if.gate lvl
);
    logic [N-1:0] levelOn;

    // Level zero means the source is off and never reaches arbitration
    always_comb begin
        for (int s = 0; s < N; s++) begin
            levelOn[s] = (lvl.level[s] != ipb_pkg::LEVEL_OFF); // RULE2
        end
    end
    assign lvl.fwd = lvl.req & levelOn; // RULE2 RULE12

    AST_OFF_NEVER_FORWARDED: assert property ( // RULE2
        @(posedge core_clk) disable iff (srst) (lvl.fwd & ~levelOn) == '0)
        else $error("Request forwarded from a source at level zero");
    AST_LIVE_REQ_FORWARDED: assert property ( // RULE12
        @(posedge core_clk) disable iff (srst)
        (lvl.req & levelOn) != '0 |-> (lvl.req & levelOn & ~lvl.fwd) == '0)
        else $error("Enabled request not forwarded in the same cycle");
endmodule
`default_nettype wire

// File: src/ipb_prio_regs.sv
// Purpose: Bank of six priority level registers behind an AXI4-Lite slave
// Assumes: Requests and bus on core_clk (200 MHz), srst synchronous high
// Notes: Levels leave straight from the register flops
//
// Function
// RULE1: Each 3-bit field is the source level itself, 001 lowest and 111 highest.
// RULE2: A field of zero switches its source off so its request never goes on.
// RULE3: Bits holding no field ignore writes and read back as zero.
// RULE4: Every field bit can be written and read back by software.
// RULE5: Reset loads every field with level four.
// RULE6: Register 0 holds timer6 at 14-12, dma_ch4_done at 10-8, compare8 at 2-0.
// RULE7: Register 1 holds timer8 at 14-12, i2c2 master 10-8, slave 6-4, timer7 2-0.
// RULE8: Register 2 holds can2 receive 14-12, ext_irq4 10-8, ext_irq3 6-4, timer9 2-0.
// RULE9: Register 3 holds encoder at 10-8, motor pwm at 6-4, can2 event at 2-0.
// RULE10: Register 4 holds fault_a at 14-12 and dma_ch5_done at 6-4.
// RULE11: Register 5 holds uart2 error 10-8, uart1 error 6-4, fault_b 2-0.
// RULE12: Each level is shown to arbitration beside its request with no added delay.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
module ipb_prio_regs #(
    parameter int unsigned ADDR_WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ipb_pkg::SRC_COUNT-1:0] srcReq,
    output logic [ipb_pkg::SRC_COUNT-1:0] fwdReq,
    output logic [3*ipb_pkg::SRC_COUNT-1:0] srcLevel
);
    localparam int unsigned NSRC = ipb_pkg::SRC_COUNT;

    // The map needs byte addresses up to 0x14
    if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin : g_bad_addr
        $error("ADDR_WIDTH must lie between 5 and 32");
    end

    // Word decode shared by the read and write paths
    function automatic logic addrHit(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] word;
        word = addr >> ipb_pkg::WORD_LSB;
        return word < ADDR_WIDTH'(ipb_pkg::REG_COUNT);
    endfunction

    function automatic logic [2:0] addrIndex(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] word;
        word = addr >> ipb_pkg::WORD_LSB;
        return word[2:0];
    endfunction

    // Byte enables of the two low lanes; upper lanes hold nothing
    function automatic logic [15:0] laneMask(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    logic [15:0] regFile_ff [0:ipb_pkg::REG_COUNT-1];
    ipb_pkg::ipb_wr_state_type wrState_ff;
    ipb_pkg::ipb_rd_state_type rdState_ff;
    logic awHeld_ff;
    logic [ADDR_WIDTH-1:0] awAddr_ff;
    logic wHeld_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic [1:0] bresp_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic awFire;
    logic wFire;
    logic arFire;
    logic wrCommit;
    logic [ADDR_WIDTH-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrHit;
    logic [2:0] wrIdx;
    logic [15:0] nxt_regWord;

    ipb_level_if #(.N(NSRC)) lvl ();

    // Channel handshakes; each address and data slot holds one item
    assign s_axi_awready = (wrState_ff == ipb_pkg::WR_IDLE) && !awHeld_ff;
    assign s_axi_wready = (wrState_ff == ipb_pkg::WR_IDLE) && !wHeld_ff;
    assign s_axi_arready = (rdState_ff == ipb_pkg::RD_IDLE);
    assign awFire = s_axi_awvalid && s_axi_awready;
    assign wFire = s_axi_wvalid && s_axi_wready;
    assign arFire = s_axi_arvalid && s_axi_arready;

    // Write goes ahead once both halves are in, whichever came first
    assign wrCommit = (wrState_ff == ipb_pkg::WR_IDLE)
        && (awHeld_ff || awFire) && (wHeld_ff || wFire);
    assign wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
    assign wrData = wHeld_ff ? wData_ff : s_axi_wdata;
    assign wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
    assign wrHit = addrHit(wrAddr);
    assign wrIdx = addrIndex(wrAddr);

    // Merge lanes, then drop unimplemented bits so they always read zero
    always_comb begin
        nxt_regWord = ((wrData[15:0] & laneMask(wrStrb))
            | (regFile_ff[wrIdx] & ~laneMask(wrStrb)))
            & ipb_pkg::REG_MASK[wrIdx]; // RULE3 RULE4
    end

    // Address half of a write waits here for its data
    always_ff @(posedge core_clk) begin
        if (srst) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (wrCommit) begin
            awHeld_ff <= 1'b0;
        end else if (awFire) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end
    end

    // Data half of a write waits here for its address
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wHeld_ff <= 1'b0;
            wData_ff <= '0;
            wStrb_ff <= '0;
        end else if (wrCommit) begin
            wHeld_ff <= 1'b0;
        end else if (wFire) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end
    end

    // Write response; unmapped words answer DECERR and change nothing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrState_ff <= ipb_pkg::WR_IDLE;
            bresp_ff <= ipb_pkg::RESP_OKAY;
        end else begin
            case (wrState_ff)
                ipb_pkg::WR_IDLE: begin
                    if (wrCommit) begin
                        wrState_ff <= ipb_pkg::WR_RESP;
                        bresp_ff <= wrHit ? ipb_pkg::RESP_OKAY : ipb_pkg::RESP_DECERR;
                    end
                end
                ipb_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wrState_ff <= ipb_pkg::WR_IDLE;
                    end
                end
                default: begin
                    wrState_ff <= ipb_pkg::WR_IDLE;
                end
            endcase
        end
    end
    assign s_axi_bvalid = (wrState_ff == ipb_pkg::WR_RESP);
    assign s_axi_bresp = bresp_ff;

    // Priority storage; reset puts every field at the middle level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int r = 0; r < ipb_pkg::REG_COUNT; r++) begin
                regFile_ff[r] <= ipb_pkg::REG_RESET[r]; // RULE5
            end
        end else if (wrCommit && wrHit) begin
            regFile_ff[wrIdx] <= nxt_regWord; // RULE4
        end
    end

    // Read path; data is captured so it stays put while rvalid waits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdState_ff <= ipb_pkg::RD_IDLE;
            rdata_ff <= '0;
            rresp_ff <= ipb_pkg::RESP_OKAY;
        end else begin
            case (rdState_ff)
                ipb_pkg::RD_IDLE: begin
                    if (arFire) begin
                        rdState_ff <= ipb_pkg::RD_DATA;
                        if (addrHit(s_axi_araddr)) begin
                            rdata_ff <= {16'h0000, regFile_ff[addrIndex(s_axi_araddr)]}; // RULE3
                            rresp_ff <= ipb_pkg::RESP_OKAY;
                        end else begin
                            rdata_ff <= 32'h0000_0000;
                            rresp_ff <= ipb_pkg::RESP_DECERR;
                        end
                    end
                end
                ipb_pkg::RD_DATA: begin
                    if (s_axi_rready) begin
                        rdState_ff <= ipb_pkg::RD_IDLE;
                    end
                end
                default: begin
                    rdState_ff <= ipb_pkg::RD_IDLE;
                end
            endcase
        end
    end
    assign s_axi_rvalid = (rdState_ff == ipb_pkg::RD_DATA);
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Field extraction: the level code is used as is, no remapping
    for (genvar s = 0; s < NSRC; s++) begin : g_src
        assign lvl.level[s] = regFile_ff[ipb_pkg::SRC_REG[s]]
            [ipb_pkg::SRC_LSB[s] +: ipb_pkg::LEVEL_WIDTH]; // RULE1 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11
        assign srcLevel[3*s +: 3] = lvl.level[s]; // RULE12
    end
    assign lvl.req = srcReq;
    assign fwdReq = lvl.fwd; // RULE12

    ipb_src_gate #(
        .N(NSRC)
    ) u_gate (
        .core_clk(core_clk),
        .srst(srst),
        .lvl(lvl)
    );

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // Expected word rebuilt lane by lane, so a broken merge cannot check itself
    logic [15:0] expWord;
    always_comb begin
        expWord = 16'h0000;
        if (wrIdx < 3'(ipb_pkg::REG_COUNT)) begin
            expWord[7:0] = wrStrb[0] ? wrData[7:0] : regFile_ff[wrIdx][7:0];
            expWord[15:8] = wrStrb[1] ? wrData[15:8] : regFile_ff[wrIdx][15:8];
            expWord = expWord & ipb_pkg::REG_MASK[wrIdx];
        end
    end

    sequence seqCommit;
        wrCommit;
    endsequence

    sequence seqRespOffered;
        s_axi_bvalid ##0 (s_axi_bresp == $past(wrHit ? ipb_pkg::RESP_OKAY
            : ipb_pkg::RESP_DECERR));
    endsequence

    sequence seqReadReq;
        arFire && addrHit(s_axi_araddr);
    endsequence

    AST_RESET_LEVELS: assert property ($fell(srst) |-> // RULE5
        srcLevel == {NSRC{ipb_pkg::LEVEL_RESET}})
        else $error("Levels not at four after reset");

    AST_WRITE_STORES: assert property (seqCommit ##0 wrHit |=> // RULE4
        regFile_ff[$past(wrIdx)] == $past(expWord))
        else $error("Register did not take written value");

    AST_WRITE_RESPONSE: assert property (seqCommit |=> seqRespOffered)
        else $error("Write response not offered one cycle after commit");

    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before bready");

    AST_READ_RETURNS: assert property (seqReadReq |=> s_axi_rvalid // RULE4
        && s_axi_rdata == {16'h0000, $past(regFile_ff[addrIndex(s_axi_araddr)])})
        else $error("Read data does not match register");

    AST_RESERVED_ZERO: assert property (s_axi_rvalid |-> // RULE3
        s_axi_rdata[31:16] == 16'h0000
        && (s_axi_rresp != ipb_pkg::RESP_OKAY
        || (s_axi_rdata[15:0] & ~(16'h7777)) == 16'h0000))
        else $error("Unimplemented bits read nonzero");

    AST_UNMAPPED_READ: assert property (arFire && !addrHit(s_axi_araddr) |=>
        s_axi_rresp == ipb_pkg::RESP_DECERR && s_axi_rdata == 32'h0000_0000)
        else $error("Unmapped read not refused");

    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read data changed before rready");

    AST_LEVEL_ONLY_BY_WRITE: assert property (!$stable(srcLevel) |-> // RULE12
        $past(wrCommit && wrHit)
        || $past(srst))
        else $error("Level changed without a register write");

    AST_TIMER6_FIELD: assert property (seqCommit ##0 wrHit // RULE6
        ##0 (wrIdx == 3'h0) && (wrStrb[1] == 1'b1) |=>
        srcLevel[2:0] == $past(wrData[14:12]))
        else $error("Timer6 level not taken from bits 14-12");

    AST_FAULTB_FIELD: assert property (seqCommit ##0 wrHit // RULE11
        ##0 (wrIdx == 3'h5) && (wrStrb[0] == 1'b1) |=>
        srcLevel[3*18 +: 3] == $past(wrData[2:0]))
        else $error("Fault B level not taken from bits 2-0");

    AST_TIMER7_FIELD: assert property (seqCommit ##0 wrHit // RULE7
        ##0 (wrIdx == 3'h1) && (wrStrb[0] == 1'b1) |=>
        srcLevel[3*6 +: 3] == $past(wrData[2:0]))
        else $error("Timer7 level not taken from bits 2-0");

    AST_ENCODER_FIELD: assert property (seqCommit ##0 wrHit // RULE9
        ##0 (wrIdx == 3'h3) && (wrStrb[1] == 1'b1) |=>
        srcLevel[3*11 +: 3] == $past(wrData[10:8]))
        else $error("Encoder level not taken from bits 10-8");

    AST_DMA5_FIELD: assert property (seqCommit ##0 wrHit // RULE10
        ##0 (wrIdx == 3'h4) && (wrStrb[0] == 1'b1) |=>
        srcLevel[3*15 +: 3] == $past(wrData[6:4]))
        else $error("DMA channel 5 level not taken from bits 6-4");

    AST_RESERVED_PER_WORD: assert property (seqReadReq |=> // RULE3
        (s_axi_rdata[15:0] & ~ipb_pkg::REG_MASK[$past(addrIndex(s_axi_araddr))]) == 16'h0000)
        else $error("Unimplemented bits of a mapped word read nonzero");

    AST_BUSY_REFUSES_WRITE: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("Write channel ready while a response is pending");

    AST_BUSY_REFUSES_READ: assert property (s_axi_rvalid |->
        !s_axi_arready)
        else $error("Read address ready while read data is pending");

    AST_READ_RESPONSE: assert property (arFire |=>
        s_axi_rvalid)
        else $error("Read data not offered one cycle after the address");

    AST_RESET_IDLE_BUS: assert property ($fell(srst) |->
        s_axi_awready && s_axi_wready && s_axi_arready
        && !s_axi_bvalid && !s_axi_rvalid)
        else $error("Bus not idle and ready after reset");

    AST_FWD_NEEDS_REQ: assert property ( // RULE2
        (fwdReq & ~srcReq) == '0)
        else $error("Request forwarded that no source raised");
endmodule
`default_nettype wire

// File: tb/ipb_arb_model.sv
// Purpose: Stand-in for the arbitration logic fed by the priority bank
// Assumes: Levels and forwarded requests settle within the same cycle
// Notes: Reports only the winning level; vector numbering is left out
`default_nettype none
module ipb_arb_model (
    input wire logic [18:0] reqPat,
    output logic [18:0] srcReq,
    input wire logic [18:0] fwdReq,
    input wire logic [56:0] srcLevel,
    output logic [2:0] winLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Requests reach the bank with no delay of their own
    assign srcReq = reqPat;
    // Highest forwarded level wins; a zero level can never win
    always_comb begin
        winLevel = 3'h0;
        for (int s = 0; s < 19; s++) begin
            if (fwdReq[s] && srcLevel[3*s +: 3] > winLevel) begin
                winLevel = srcLevel[3*s +: 3];
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/ipb_prio_regs_tb.sv
// Purpose: Self-checking bench for the priority level register bank
// Assumes: Bank answers over AXI4-Lite, arbitration model on the far side
// Notes: Expected register words are rebuilt from the field table
`default_nettype none
module ipb_prio_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awAddr = 8'h00;
    logic [7:0] arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'h0;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [18:0] reqPat = 19'h0;
    logic [18:0] srcReq, fwdReq;
    logic [56:0] srcLevel;
    logic [2:0] winLevel;
    logic [2:0] lv [0:18];
    int mismatches = 0;
    int checked = 0;

    ipb_prio_regs u_ipb_prio_regs (.core_clk(core_clk), .srst(srst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .srcReq(srcReq),
        .fwdReq(fwdReq), .srcLevel(srcLevel));
    ipb_arb_model u_ipb_arb_model (.reqPat(reqPat), .srcReq(srcReq), .fwdReq(fwdReq),
        .srcLevel(srcLevel), .winLevel(winLevel));

    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One clock of waiting; a hung bus ends the run instead of stalling it
    task automatic tick(inout int n);
        @(posedge core_clk);
        n++;
        if (n > 100) begin
            mismatches++;
            $display("[ERR] bus answer expected within 100 cycles seen none");
            give_verdict();
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] resp);
        int n = 0;
        @(posedge core_clk);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        forever begin
            tick(n);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) begin
                resp = bResp;
                bReady <= 1'b0;
                break;
            end
        end
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] resp);
        int n = 0;
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        forever begin
            tick(n);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) begin
                d = rData;
                resp = rResp;
                rReady <= 1'b0;
                break;
            end
        end
    endtask

    // Register word from the current levels, or its field mask
    function automatic logic [31:0] reg_val(input int r, input bit ones);
        logic [31:0] v = 32'h0;
        for (int s = 0; s < 19; s++) begin
            if (ipb_pkg::SRC_REG[s] == r) begin
                v |= (ones ? 32'h7 : 32'(lv[s])) << ipb_pkg::SRC_LSB[s];
            end
        end
        return v;
    endfunction

    // Unused bits are written as ones so any leak shows on readback
    task automatic set_all();
        logic [1:0] resp;
        for (int r = 0; r < 6; r++) begin
            bus_write(8'(4*r), reg_val(r, 0) | ~reg_val(r, 1), 4'hf, resp);
            cmp_resp("write response", ipb_pkg::RESP_OKAY, resp);
        end
    endtask

    task automatic check_all(input logic [18:0] pat);
        logic [31:0] d;
        logic [1:0] resp;
        logic [2:0] best = 3'h0;
        logic [18:0] expFwd = 19'h0;
        for (int r = 0; r < 6; r++) begin
            bus_read(8'(4*r), d, resp);
            cmp_resp("read response", ipb_pkg::RESP_OKAY, resp);
            cmp_word("register readback", reg_val(r, 0), d);
        end
        reqPat <= pat;
        @(negedge core_clk);
        for (int s = 0; s < 19; s++) begin
            cmp_word("source level", 32'(lv[s]), 32'(srcLevel[3*s +: 3]));
            if (pat[s] && lv[s] != 3'h0) begin
                expFwd[s] = 1'b1;
                if (lv[s] > best) best = lv[s];
            end
        end
        cmp_word("forwarded requests", 32'(expFwd), 32'(fwdReq));
        cmp_word("winning level", 32'(best), 32'(winLevel));
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] resp;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        foreach (lv[s]) lv[s] = 3'h4;
        check_all(19'h7ffff);
        bus_read(8'h18, d, resp);
        cmp_resp("unmapped read response", ipb_pkg::RESP_DECERR, resp);
        cmp_word("unmapped read data", 32'h0, d);
        bus_write(8'h18, 32'hffff_ffff, 4'hf, resp);
        cmp_resp("unmapped write response", ipb_pkg::RESP_DECERR, resp);
        check_all(19'h7ffff);
        $display("Test reset_and_decode done");
        // Every code from off to top level on every field
        for (int k = 0; k < 8; k++) begin
            foreach (lv[s]) lv[s] = 3'(k);
            set_all();
            check_all(19'h7ffff);
        end
        $display("Test uniform_levels done");
        // Distinct levels inside each word catch swapped or shifted fields
        foreach (lv[s]) lv[s] = 3'(s % 8);
        set_all();
        check_all(19'h55555);
        foreach (lv[s]) lv[s] = 3'(7 - s % 8);
        set_all();
        check_all(19'h2aaaa);
        $display("Test field_positions done");
        // Byte lanes: only strobed lanes change
        bus_write(8'h04, 32'h0000_1111, 4'h1, resp);
        cmp_resp("lane write response", ipb_pkg::RESP_OKAY, resp);
        lv[5] = 3'h1;
        lv[6] = 3'h1;
        check_all(19'h7ffff);
        bus_write(8'h05, 32'h0000_2200, 4'h2, resp);
        cmp_resp("lane write response", ipb_pkg::RESP_OKAY, resp);
        lv[3] = 3'h2;
        lv[4] = 3'h2;
        check_all(19'h7ffff);
        $display("Test byte_lanes done");
        // Reset in mid-run must bring every field back to four
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        foreach (lv[s]) lv[s] = 3'h4;
        check_all(19'h7ffff);
        $display("Test mid_run_reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
